// [verilog/mesr_defines.vh]
// Purpose: Offsets, field layouts, reset values and codes for the
//          motor estimator status register bank.
// Assumes: Register offsets are word indices; byte address is index * 4.
// Notes:   Definitions only; included by its bare name.
`ifndef MESR_DEFINES_VH
`define MESR_DEFINES_VH

// Register indices as printed (byte address = index * 4)
`define MESR_IDX_PHASE          12'h6c0
`define MESR_IDX_INIT_ANGLE     12'h704
`define MESR_IDX_BEMF_D         12'h74a
`define MESR_IDX_BEMF_Q         12'h74c
`define MESR_IDX_RATE           12'h75a
`define MESR_IDX_ANGLE          12'h75e
// Own status register: bit 0 shows a pending, not yet committed result
`define MESR_IDX_STATUS         12'h7f0

// Byte address width of the slave
`define MESR_ADDR_W             14

// Reset values
`define MESR_RST_WORD           32'h00000000
`define MESR_RST_PHASE          16'h0000

// Field layout
`define MESR_PHASE_W            16
`define MESR_FRAC_BITS          27
`define MESR_STATUS_PEND_BIT    0

// Initial position phase codes
`define MESR_PH_INIT            16'h0000
`define MESR_PH_VECTOR_CFG      16'h0001
`define MESR_PH_RUN             16'h0002
`define MESR_PH_SLOW_RISE       16'h0003
`define MESR_PH_SLOW_FALL       16'h0004
`define MESR_PH_DECAY_WAIT      16'h0005
`define MESR_PH_GET_TIMES       16'h0006
`define MESR_PH_NEXT_VECTOR     16'h0007
`define MESR_PH_SECTOR_CALC     16'h0008
`define MESR_PH_POSITION_CALC   16'h0009
`define MESR_PH_ANGLE_CALC      16'h000a
`define MESR_PH_COMPLETE        16'h000b
`define MESR_PH_FAULT           16'h000c

// AXI responses
`define MESR_RESP_OKAY          2'b00
`define MESR_RESP_SLVERR        2'b10

`endif

// [verilog/mesr_word_hold.v]
// Purpose: One result register that loads a whole word at once.
// Assumes: Producer presents the complete word with a one-cycle load.
// Notes:   Read side always sees either the old or the new word.
`timescale 1ns/1ns
`include "mesr_defines.vh"

module mesr_word_hold
#(
  parameter                W   = 32,
  parameter [W-1:0]        RST = {W{1'b0}}
)
(
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              load,
  input  wire [W-1:0]      din,
  output reg  [W-1:0]      dout_r
);

  // Whole-word load, cleared by reset
  always @(posedge aclk)
  begin
    if (!aresetn)
      dout_r <= RST;
    else if (load)
      dout_r <= din;
  end

endmodule

// [verilog/mesr_status_regs.v]
// Purpose: Read-only status bank of a sensorless motor controller,
//          read by software over AXI4-Lite.
// Assumes: Results arrive from the control algorithm with strobes,
//          synchronous to aclk; writes from software are refused.
// Notes:   Results are taken into a staging set and committed together
//          on commit, so related words change in the same cycle.
//          Register map by word index (byte address = index * 4):
//            0x6c0  initial position phase, code in bits 15:0
//            0x704  initial rotor angle, signed
//            0x74a  direct-axis back-EMF estimate, signed
//            0x74c  quadrature-axis back-EMF estimate, signed
//            0x75a  rotor rate estimate, signed
//            0x75e  rotor angle estimate, signed
//            0x7f0  own status, bit 0 = staged result awaiting commit
//          Any other index reads zero with a slave error response.
//          Every 32-bit result is fixed point with 27 fraction bits:
//            angle words:    degrees = value / 2^27 * 360
//            back-EMF words: value / 2^27 * 60 / sqrt(3)
//            rate word:      hertz = value / 2^27 * configured_top_rate
//          The rate is positive for phase order a-b-c, negative for a-c-b.
//          Phase codes held in the phase register:
//            0x0  start of the position search
//            0x1  setting up the test vector
//            0x2  vector applied
//            0x3  timing the slow current rise
//            0x4  timing the slow current fall
//            0x5  waiting for the current to decay
//            0x6  collecting the measured times
//            0x7  moving to the next vector
//            0x8  working out the sector
//            0x9  working out the rotor position
//            0xa  working out the angle
//            0xb  search complete
//            0xc  search faulted
//          Bus behaviour:
//            a read answers one cycle after its address is taken;
//            the answer stands until rready is seen high;
//            one read and one write at most are under way at a time;
//            every write is refused with a slave error, nothing changes.
//          Coherence:
//            a result strobe stages its word and marks it pending;
//            commit copies every pending word to its readable register;
//            a strobe in the commit cycle waits for the next commit,
//            and the word staged before it is the one committed.
//          Phase codes skip staging and show one cycle after the strobe.
//          A producer that never commits leaves old values readable.
//          wdata, wstrb and the prot fields are never looked at.
// What this block does
// - Phase register is a 16-bit read-only code, values 0h to Ch.
// - Initial rotor angle is 32-bit signed, degrees = value/2^27*360.
// - Direct back-EMF estimate is 32-bit two's complement, scaled 60/sqrt3.
// - Quadrature back-EMF estimate is 32-bit two's complement, 60/sqrt3.
// - Rotor rate is 32-bit signed, positive A-B-C, negative A-C-B.
// - Rotor angle estimate is 32-bit two's complement, degrees scaled 360.
// - All 32-bit result registers read zero after reset.
`timescale 1ns/1ns
`include "mesr_defines.vh"

module mesr_status_regs
#(
  parameter                    ADDR_W = `MESR_ADDR_W
)
(
  input  wire                  aclk,
  input  wire                  aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0]     s_axi_awaddr,
  input  wire [2:0]            s_axi_awprot,
  input  wire                  s_axi_awvalid,
  output wire                  s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output wire                  s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0]     s_axi_araddr,
  input  wire [2:0]            s_axi_arprot,
  input  wire                  s_axi_arvalid,
  output wire                  s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready,
  // Results from the control algorithm
  input  wire [15:0]           phase_in,
  input  wire                  phase_we,
  input  wire [31:0]           init_angle_in,
  input  wire                  init_angle_we,
  input  wire [31:0]           bemf_d_in,
  input  wire                  bemf_d_we,
  input  wire [31:0]           bemf_q_in,
  input  wire                  bemf_q_we,
  input  wire [31:0]           rate_in,
  input  wire                  rate_we,
  input  wire [31:0]           angle_in,
  input  wire                  angle_we,
  input  wire                  commit
);

  localparam NW = 5;

  // Write channel state
  reg                          aw_got_r;
  reg                          w_got_r;
  // Staging set and pending flags
  reg  [31:0]                  stage_r [0:NW-1];
  reg  [NW-1:0]                pend_r;
  reg  [15:0]                  phase_r;
  wire [31:0]                  word_q [0:NW-1];
  wire [32*NW-1:0]             word_bus;
  wire [NW-1:0]                we_vec;
  wire [11:0]                  rd_idx;
  reg  [31:0]                  rd_data;
  reg                          rd_hit;
  integer                      i;
  // Next values of the phase code and of the bus side
  reg  [15:0]                  phase_nxt;
  reg                          aw_got_nxt;
  reg                          w_got_nxt;
  reg                          bvalid_nxt;
  reg                          rvalid_nxt;
  reg  [31:0]                  rdata_nxt;
  reg  [1:0]                   rresp_nxt;

  assign we_vec = {angle_we, rate_we, bemf_q_we, bemf_d_we, init_angle_we};
  assign word_bus = {angle_in, rate_in, bemf_q_in, bemf_d_in, init_angle_in};

  // Phase code next value: a new code replaces the old one whole
  always @*
  begin
    phase_nxt = phase_r;
    if (phase_we)
      phase_nxt = phase_in;
  end

  // Phase code taken whole, zero after reset
  always @(posedge aclk)
  begin
    if (!aresetn)
      phase_r <= `MESR_RST_PHASE;
    else
      phase_r <= phase_nxt;
  end

  // Staging words; a strobe that meets commit is held for the next one
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_r <= {NW{1'b0}};
      for (i = 0; i < NW; i = i + 1)
        stage_r[i] <= `MESR_RST_WORD;
    end
    else
    begin
      for (i = 0; i < NW; i = i + 1)
      begin
        if (we_vec[i])
        begin
          stage_r[i] <= word_bus[32*i +: 32];
          pend_r[i]  <= 1'b1;
        end
        else if (commit)
          pend_r[i] <= 1'b0;
      end
    end
  end

  // Committed initial rotor angle, loaded as one word
  mesr_word_hold
  #(
    .W   (32),
    .RST (`MESR_RST_WORD)
  )
  u_hold_init_angle
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (commit & pend_r[0]),
    .din     (stage_r[0]),
    .dout_r  (word_q[0])
  );

  // Committed direct-axis back-EMF estimate
  mesr_word_hold
  #(
    .W   (32),
    .RST (`MESR_RST_WORD)
  )
  u_hold_bemf_d
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (commit & pend_r[1]),
    .din     (stage_r[1]),
    .dout_r  (word_q[1])
  );

  // Committed quadrature-axis back-EMF estimate
  mesr_word_hold
  #(
    .W   (32),
    .RST (`MESR_RST_WORD)
  )
  u_hold_bemf_q
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (commit & pend_r[2]),
    .din     (stage_r[2]),
    .dout_r  (word_q[2])
  );

  // Committed rotor rate estimate
  mesr_word_hold
  #(
    .W   (32),
    .RST (`MESR_RST_WORD)
  )
  u_hold_rate
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (commit & pend_r[3]),
    .din     (stage_r[3]),
    .dout_r  (word_q[3])
  );

  // Committed rotor angle estimate
  mesr_word_hold
  #(
    .W   (32),
    .RST (`MESR_RST_WORD)
  )
  u_hold_angle
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (commit & pend_r[4]),
    .din     (stage_r[4]),
    .dout_r  (word_q[4])
  );

  // Write side: accept address and data in either order, refuse the write
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;

  // Write side next state; the answer follows the later of aw and w
  always @*
  begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    bvalid_nxt = s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready)
      aw_got_nxt = 1'b1;
    if (s_axi_wvalid && s_axi_wready)
      w_got_nxt = 1'b1;
    if (aw_got_nxt && w_got_nxt && !s_axi_bvalid)
    begin
      bvalid_nxt = 1'b1;
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
      bvalid_nxt = 1'b0;
  end

  // Write side registers; every write is answered with a refusal
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MESR_RESP_OKAY;
    end
    else
    begin
      aw_got_r     <= aw_got_nxt;
      w_got_r      <= w_got_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (bvalid_nxt && !s_axi_bvalid)
        s_axi_bresp <= `MESR_RESP_SLVERR; // All registers read-only
    end
  end

  // Read side: word index from the byte address
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx = s_axi_araddr[13:2];

  // Read decode
  always @*
  begin
    rd_data = 32'h00000000;
    rd_hit  = 1'b1;
    case (rd_idx)
      `MESR_IDX_PHASE:      rd_data = {16'h0000, phase_r};
      `MESR_IDX_INIT_ANGLE: rd_data = word_q[0];
      `MESR_IDX_BEMF_D:     rd_data = word_q[1];
      `MESR_IDX_BEMF_Q:     rd_data = word_q[2];
      `MESR_IDX_RATE:       rd_data = word_q[3];
      `MESR_IDX_ANGLE:      rd_data = word_q[4];
      `MESR_IDX_STATUS:     rd_data = {31'h00000000, |pend_r};
      default:              rd_hit  = 1'b0;
    endcase
  end

  // Read answer next state, one cycle after the address is taken
  always @*
  begin
    rvalid_nxt = s_axi_rvalid;
    rdata_nxt  = s_axi_rdata;
    rresp_nxt  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_data;
      rresp_nxt  = rd_hit ? `MESR_RESP_OKAY : `MESR_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      rvalid_nxt = 1'b0;
  end

  // Read answer registers; the answer stands until rready
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `MESR_RESP_OKAY;
    end
    else
    begin
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rdata  <= rdata_nxt;
      s_axi_rresp  <= rresp_nxt;
    end
  end

endmodule

// [testbench/mesr_status_regs_monitor.sv]
// Purpose: Port checks on the estimator status bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ns
`include "mesr_defines.vh"
module mesr_status_regs_monitor
#(
  parameter ADDR_W = `MESR_ADDR_W
)
(
  input wire              aclk,
  input wire              aresetn,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire [31:0]       s_axi_rdata,
  input wire [1:0]        s_axi_rresp,
  input wire              s_axi_rvalid,
  input wire              s_axi_rready,
  input wire [1:0]        s_axi_bresp,
  input wire              s_axi_bvalid
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Read request taken and the word index it names
  wire        ar = s_axi_arvalid && s_axi_arready;
  wire [11:0] ix = s_axi_araddr[13:2];
  a_read_next: assert property (ar |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed before taken");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_refused: assert property (s_axi_bvalid |->
    s_axi_bresp == `MESR_RESP_SLVERR)
    else $error("write to read-only bank accepted");
  a_phase_upper: assert property (ar && ix == `MESR_IDX_PHASE |=>
    s_axi_rdata[31:16] == 16'h0 && s_axi_rresp == 2'b00)
    else $error("phase word upper half not zero");
  a_bemf_okay: assert property (ar && (ix == `MESR_IDX_BEMF_D ||
    ix == `MESR_IDX_BEMF_Q) |=> s_axi_rresp == 2'b00)
    else $error("back-emf read refused");
  a_motion_okay: assert property (ar && (ix == `MESR_IDX_RATE ||
    ix == `MESR_IDX_ANGLE || ix == `MESR_IDX_INIT_ANGLE)
    |=> s_axi_rresp == 2'b00)
    else $error("motion read refused");
  a_reset_zero: assert property ($rose(aresetn) |->
    !s_axi_rvalid && !s_axi_bvalid && s_axi_rdata == 32'h0)
    else $error("bank not idle after reset");
endmodule
bind mesr_status_regs mesr_status_regs_monitor #(.ADDR_W(ADDR_W)) mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid));

// [testbench/mesr_status_regs_tb.sv]
// Purpose: Self-checking bench for the estimator status bank
// Assumes: AXI4-Lite master driving at the rising edge
// Notes:   Expected answers queue up; a monitor pops and compares them
`timescale 1ns/1ns
`include "mesr_defines.vh"
module mesr_status_regs_tb;
  logic        aclk, aresetn, awv, wv, arv, rready, bready, commit, ph_we;
  logic [13:0] awa, ara;
  logic [31:0] wd, w [5], a [5];
  logic [15:0] ph;
  logic [4:0]  we;
  wire         awready, wready, bvalid, arready, rvalid;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  logic [33:0] q [$];
  integer      miscompares, comparisons, seed, i;
  localparam logic [11:0] IX [5] = '{`MESR_IDX_INIT_ANGLE,
    `MESR_IDX_BEMF_D, `MESR_IDX_BEMF_Q, `MESR_IDX_RATE, `MESR_IDX_ANGLE};
  mesr_status_regs uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .phase_in(ph), .phase_we(ph_we),
    .init_angle_in(w[0]), .init_angle_we(we[0]), .bemf_d_in(w[1]),
    .bemf_d_we(we[1]), .bemf_q_in(w[2]), .bemf_q_we(we[2]),
    .rate_in(w[3]), .rate_we(we[3]), .angle_in(w[4]), .angle_we(we[4]),
    .commit(commit));
  // Clock of 40 ns
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Compares each answer with the oldest expectation
  always @(posedge aclk)
  begin
    if ((rvalid && rready) || (bvalid && bready))
      chk(rvalid ? {rresp, rdata} : {bresp, 32'h0}, q.pop_front());
  end
  task chk(input [33:0] g, input [33:0] x);
  begin
    comparisons++;
    if (g !== x)
    begin
      miscompares++;
      $display("Error at %0t got %h expected %h", $time, g, x);
    end
  end
  endtask
  task finish_test;
  begin
    $display("Comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // A wait that used up its bound ends the run
  task tmo(input integer n);
  begin
    if (n >= 50)
    begin
      miscompares++;
      finish_test;
    end
  end
  endtask
  task rd(input [11:0] ix, input [33:0] x);
    integer n;
  begin
    q.push_back(x);
    arv <= 1'b1;
    ara <= {ix, 2'b00};
    n = 0;
    do @(posedge aclk); while (!arready && ++n < 50);
    arv <= 1'b0;
    do @(posedge aclk); while (!rvalid && ++n < 50);
    tmo(n);
  end
  endtask
  task wr(input [11:0] ix);
    integer n;
  begin
    q.push_back({`MESR_RESP_SLVERR, 32'h0});
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= {ix, 2'b00};
    wd <= $random(seed);
    n = 0;
    do
    begin
      @(posedge aclk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (!bvalid && ++n < 50);
    tmo(n);
  end
  endtask
  // Presents random results on the masked strobes, with optional commit
  task load(input [4:0] m, input c);
  begin
    for (i = 0; i < 5; i++) if (m[i]) w[i] <= $random(seed);
    we <= m;
    commit <= c;
    @(posedge aclk);
    we <= 5'h0;
    commit <= 1'b0;
  end
  endtask
  initial
  begin
    seed = 61; miscompares = 0; comparisons = 0; aresetn = 1'b0;
    awv = 0; wv = 0; arv = 0; rready = 1; bready = 1; commit = 0;
    we = 0; ph_we = 0; ph = 0; awa = 0; ara = 0; wd = 0; w = '{5{0}};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 5; i++) rd(IX[i], 34'h0);
    rd(12'h000, {`MESR_RESP_SLVERR, 32'h0});
    wr(IX[0]);
    wr(`MESR_IDX_PHASE);
    rd(IX[0], 34'h0);
    for (i = 0; i <= 12; i++)
    begin
      ph <= i[15:0];
      ph_we <= 1'b1;
      @(posedge aclk);
      ph_we <= 1'b0;
      rd(`MESR_IDX_PHASE, {18'h0, i[15:0]});
    end
    load(5'h1f, 1'b0);
    a = w;
    rd(`MESR_IDX_STATUS, 34'h1);
    rd(IX[3], 34'h0);
    load(5'h1f, 1'b1);
    for (i = 0; i < 5; i++) rd(IX[i], {2'b00, a[i]});
    rd(`MESR_IDX_STATUS, 34'h1);
    load(5'h0, 1'b1);
    for (i = 0; i < 5; i++) rd(IX[i], {2'b00, w[i]});
    rd(`MESR_IDX_STATUS, 34'h0);
    // Late rready: the answer must stand until it is taken
    rready <= 1'b0;
    rd(IX[4], {2'b00, w[4]});
    repeat (2) @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(IX[3], 34'h0);
    @(posedge aclk);
    finish_test;
  end
endmodule
